// ### common/slps_pkg.sv
`default_nettype none
package slps_pkg;
    // Pads that take part in strapping and carry general-purpose functions
    localparam int GPIO_NUM = 11;
    localparam int ADDR_W = 5;

    // Register byte offsets
    localparam logic [4:0] REG_STRAP = 5'h00;
    localparam logic [4:0] REG_GPIO_OUT = 5'h04;
    localparam logic [4:0] REG_GPIO_DRIVE = 5'h08;
    localparam logic [4:0] REG_PULL_UP = 5'h0c;
    localparam logic [4:0] REG_PULL_DOWN = 5'h10;
    localparam logic [4:0] REG_CTRL = 5'h14;
    localparam logic [4:0] REG_GPIO_IN = 5'h18;

    // Strap status fields
    localparam int ST_HOST_LSB = 0;
    localparam int ST_FUSE_BIT = 2;
    localparam int ST_FLASH_PRESENT_BIT = 3;
    localparam int ST_FLASH_VENDOR_BIT = 4;
    localparam int ST_BOOT_ROM_BIT = 5;
    localparam int ST_LEVEL_LSB = 6;
    localparam int ST_XTAL_POL_BIT = 8;
    localparam int ST_DONE_BIT = 31;
    localparam int STRAP_W = 9;

    // Control fields
    localparam int CTRL_REG_PD_DIS_BIT = 0;
    localparam int CTRL_CORE_RUN_BIT = 1;

    // Pad index of each strap on the general-purpose pads
    localparam int PIN_LEVEL0 = 0;
    localparam int PIN_LEVEL1 = 1;
    localparam int PIN_HOST_HI = 6;
    localparam int PIN_FUSE = 7;
    localparam int PIN_FLASH_PRESENT = 8;
    localparam int PIN_BOOT = 9;
    localparam int PIN_FLASH_VENDOR = 10;

    // Pull reset values, normal operation and strap window
    localparam logic [10:0] PULL_UP_RST = 11'h7ae;
    localparam logic [10:0] PULL_DOWN_RST = 11'h041;
    localparam logic [10:0] STRAP_PULL_UP = 11'h2ae;
    localparam logic [10:0] STRAP_PULL_DOWN = 11'h541;
    localparam logic [10:0] GPIO_OUT_RST = 11'h000;
    localparam logic [10:0] GPIO_DRIVE_RST = 11'h000;
    localparam logic [1:0] CTRL_RST = 2'h0;

    // Strap delay after the regulator enable pin goes high
    localparam int CLK_PERIOD_NS = 20;
    localparam int STRAP_DELAY_US = 3000;
    localparam int STRAP_DELAY_CYCLES = (STRAP_DELAY_US * 1000) / CLK_PERIOD_NS;
endpackage
`default_nettype wire

// ### hdl/slps_sync.sv
`timescale 1ns/100ps
`default_nettype none
module slps_sync #(
    parameter int WIDTH = 1
) (
    input wire logic clk, // System clock
    input wire logic reset, // Synchronous reset, active high
    input wire logic [WIDTH-1:0] d, // Asynchronous inputs
    output logic [WIDTH-1:0] q // Synchronised inputs
);
    typedef struct packed {
        logic [WIDTH-1:0] meta;
        logic [WIDTH-1:0] stable;
    } slps_sync_type;

    slps_sync_type state_ff;
    slps_sync_type nxt_state;

    if (WIDTH < 1) begin : g_bad_width
        $error("slps_sync: WIDTH must be at least 1");
    end

    always_comb begin
        nxt_state.meta = d;
        nxt_state.stable = state_ff.meta;
    end

    always_ff @(posedge clk) begin
        if (reset) begin
            state_ff <= '0;
        end else begin
            state_ff <= nxt_state;
        end
    end

    assign q = state_ff.stable;
endmodule
`default_nettype wire

// ### hdl/slps_top.sv
// Decided for this implementation: the placing of the registers and the Avalon-MM slave port.
`timescale 1ns/100ps
`default_nettype none
module slps_top #(
    parameter int unsigned STRAP_DELAY_CYCLES = slps_pkg::STRAP_DELAY_CYCLES,
    parameter int CNT_W = 18
) (
    input wire logic clk, // 50 MHz clock
    input wire logic reset, // Power-on reset, high
    // Avalon-MM slave
    input wire logic [slps_pkg::ADDR_W-1:0] address, // Byte address
    input wire logic read, // Read request
    input wire logic write, // Write request
    input wire logic [3:0] byteenable, // Write lanes
    input wire logic [31:0] writedata, // Write data
    output logic [31:0] readdata, // Read data
    output logic waitrequest, // Stall
    // General-purpose strap pads
    input wire logic [slps_pkg::GPIO_NUM-1:0] gpioIn, // Pad levels
    output logic [slps_pkg::GPIO_NUM-1:0] gpioOut, // Pad drive value
    output logic [slps_pkg::GPIO_NUM-1:0] gpioOeN, // Low while driving
    output logic [slps_pkg::GPIO_NUM-1:0] gpioPullUp, // Pull-up on
    output logic [slps_pkg::GPIO_NUM-1:0] gpioPullDown, // Pull-down on
    output logic [slps_pkg::GPIO_NUM-1:0] gpioKeeper, // Keeper on
    // Low host strap pad, alternate function after sampling
    input wire logic hostStrapIn, // Pad level
    output logic hostStrapPullDown, // Strap pull-down
    // Crystal power-up pad
    input wire logic crystalPadIn, // Pad level
    input wire logic crystalRequest, // Crystal wanted
    output logic crystal_powerup_out, // Pad drive value
    output logic crystalPadOeN, // Low while driving
    output logic crystalPadPullDown, // Strap pull-down
    // Regulator enable pad
    input wire logic regulator_enable_in, // Enable pin
    output logic regEnablePullDown, // Pin pull-down
    output logic sectionReset, // Section reset
    output logic regulatorsOn, // Regulators up
    // Latched straps
    output logic strapDone, // Straps latched
    output logic [1:0] hostMode, // Host port mode
    output logic fuseMemoryPowerOn, // Fuse memory power
    output logic flashPresent, // Flash attached
    output logic flashVendorFirst, // Flash command set
    output logic bootFromRom, // ROM boot, remap
    output logic [1:0] power_up_level_strap, // Power manager target
    output logic coreHoldReset // Core held
);
    typedef enum {
        PH_WAIT_POWER,
        PH_COUNT,
        PH_DONE
    } slps_phase_type;

    typedef struct packed {
        slps_phase_type phase;
        logic [CNT_W-1:0] delayCnt;
        logic [slps_pkg::STRAP_W-1:0] straps;
        logic done;
        logic [10:0] outVal;
        logic [10:0] drive;
        logic [10:0] pullUpReg;
        logic [10:0] pullDownReg;
        logic [1:0] ctrl;
        logic ack;
        logic [31:0] rdata;
        logic [10:0] padOut;
        logic [10:0] padOeN;
        logic [10:0] padUp;
        logic [10:0] padDown;
        logic [10:0] padKeep;
        logic hostPd;
        logic xtalOut;
        logic xtalOeN;
        logic xtalPd;
        logic regPd;
        logic powered;
    } slps_state_type;

    localparam logic [CNT_W-1:0] DELAY_LAST = CNT_W'(STRAP_DELAY_CYCLES - 1);

    if (STRAP_DELAY_CYCLES < 1 || STRAP_DELAY_CYCLES > (2 ** CNT_W)) begin : g_bad_delay
        $error("slps_top: STRAP_DELAY_CYCLES does not fit CNT_W");
    end
    if (slps_pkg::GPIO_NUM != 11) begin : g_bad_pads
        $error("slps_top: pad count must be 11");
    end

    slps_state_type state_ff;
    slps_state_type nxt_state;

    logic [10:0] padSync;
    logic hostSync;
    logic xtalSync;
    logic regOnSync;
    logic busReq;

    // Pad levels cross in before any use
    slps_sync #(
        .WIDTH(14)
    ) u_sync (
        .clk(clk),
        .reset(reset),
        .d({regulator_enable_in, crystalPadIn, hostStrapIn, gpioIn}),
        .q({regOnSync, xtalSync, hostSync, padSync})
    );

    function automatic logic [10:0] slps_apply_be(
        input logic [10:0] old,
        input logic [31:0] wd,
        input logic [3:0] be
    );
        logic [10:0] res;
        res = old;
        if (be[0]) begin
            res[7:0] = wd[7:0];
        end
        if (be[1]) begin
            res[10:8] = wd[10:8];
        end
        return res;
    endfunction

    assign busReq = read || write;
    // One wait state on every access
    assign waitrequest = busReq && !state_ff.ack;

    always_comb begin
        nxt_state = state_ff;
        nxt_state.ack = busReq && !state_ff.ack;

        // Read data prepared in the wait cycle, valid at the accepting edge
        if (busReq && !state_ff.ack) begin
            case (address)
                slps_pkg::REG_STRAP: begin
                    nxt_state.rdata = 32'h0;
                    nxt_state.rdata[slps_pkg::STRAP_W-1:0] = state_ff.straps;
                    nxt_state.rdata[slps_pkg::ST_DONE_BIT] = state_ff.done;
                end
                slps_pkg::REG_GPIO_OUT: begin
                    nxt_state.rdata = {21'h0, state_ff.outVal};
                end
                slps_pkg::REG_GPIO_DRIVE: begin
                    nxt_state.rdata = {21'h0, state_ff.drive};
                end
                slps_pkg::REG_PULL_UP: begin
                    nxt_state.rdata = {21'h0, state_ff.pullUpReg};
                end
                slps_pkg::REG_PULL_DOWN: begin
                    nxt_state.rdata = {21'h0, state_ff.pullDownReg};
                end
                slps_pkg::REG_CTRL: begin
                    nxt_state.rdata = {30'h0, state_ff.ctrl};
                end
                slps_pkg::REG_GPIO_IN: begin
                    nxt_state.rdata = {21'h0, padSync};
                end
                default: begin
                    nxt_state.rdata = 32'h0;
                end
            endcase
        end

        // Writes land at the edge where waitrequest is low
        if (write && state_ff.ack) begin
            case (address)
                slps_pkg::REG_GPIO_OUT: begin
                    nxt_state.outVal = slps_apply_be(state_ff.outVal, writedata, byteenable);
                end
                slps_pkg::REG_GPIO_DRIVE: begin
                    nxt_state.drive = slps_apply_be(state_ff.drive, writedata, byteenable);
                end
                slps_pkg::REG_PULL_UP: begin
                    nxt_state.pullUpReg =
                        slps_apply_be(state_ff.pullUpReg, writedata, byteenable);
                end
                slps_pkg::REG_PULL_DOWN: begin
                    nxt_state.pullDownReg =
                        slps_apply_be(state_ff.pullDownReg, writedata, byteenable);
                end
                slps_pkg::REG_CTRL: begin
                    if (byteenable[0]) begin
                        nxt_state.ctrl = writedata[1:0];
                    end
                end
                default: begin
                end
            endcase
        end

        // Strap sequencer; pads are meaningless until the section has power
        case (state_ff.phase)
            PH_WAIT_POWER: begin
                nxt_state.delayCnt = '0;
                if (regOnSync) begin
                    nxt_state.phase = PH_COUNT;
                end
            end
            PH_COUNT: begin
                if (!regOnSync) begin
                    nxt_state.phase = PH_WAIT_POWER;
                end else if (state_ff.delayCnt == DELAY_LAST) begin
                    nxt_state.straps[slps_pkg::ST_HOST_LSB+1] = padSync[slps_pkg::PIN_HOST_HI];
                    nxt_state.straps[slps_pkg::ST_HOST_LSB] = hostSync;
                    nxt_state.straps[slps_pkg::ST_FUSE_BIT] = padSync[slps_pkg::PIN_FUSE];
                    nxt_state.straps[slps_pkg::ST_FLASH_PRESENT_BIT] =
                        padSync[slps_pkg::PIN_FLASH_PRESENT];
                    nxt_state.straps[slps_pkg::ST_FLASH_VENDOR_BIT] =
                        padSync[slps_pkg::PIN_FLASH_VENDOR];
                    nxt_state.straps[slps_pkg::ST_BOOT_ROM_BIT] = padSync[slps_pkg::PIN_BOOT];
                    nxt_state.straps[slps_pkg::ST_LEVEL_LSB+1] = padSync[slps_pkg::PIN_LEVEL1];
                    nxt_state.straps[slps_pkg::ST_LEVEL_LSB] = padSync[slps_pkg::PIN_LEVEL0];
                    nxt_state.straps[slps_pkg::ST_XTAL_POL_BIT] = xtalSync;
                    nxt_state.done = 1'b1;
                    nxt_state.phase = PH_DONE;
                end else begin
                    nxt_state.delayCnt = state_ff.delayCnt + CNT_W'(1);
                end
            end
            PH_DONE: begin
                // Only reset leaves this state, so straps never change again
                nxt_state.phase = PH_DONE;
            end
            default: begin
                nxt_state.phase = PH_WAIT_POWER;
            end
        endcase

        // Section held in reset: software state returns to defaults
        if (!regOnSync) begin
            nxt_state.outVal = slps_pkg::GPIO_OUT_RST;
            nxt_state.drive = slps_pkg::GPIO_DRIVE_RST;
            nxt_state.pullUpReg = slps_pkg::PULL_UP_RST;
            nxt_state.pullDownReg = slps_pkg::PULL_DOWN_RST;
            nxt_state.ctrl = slps_pkg::CTRL_RST;
        end

        nxt_state.powered = regOnSync;
        nxt_state.regPd = !regOnSync || !state_ff.ctrl[slps_pkg::CTRL_REG_PD_DIS_BIT];
        nxt_state.padKeep = regOnSync ? 11'h7ff : 11'h000;

        if (!regOnSync) begin
            // Pads unpowered: released, no pull
            nxt_state.padOut = 11'h000;
            nxt_state.padOeN = 11'h7ff;
            nxt_state.padUp = 11'h000;
            nxt_state.padDown = 11'h000;
            nxt_state.hostPd = 1'b0;
            nxt_state.xtalOut = 1'b0;
            nxt_state.xtalOeN = 1'b1;
            nxt_state.xtalPd = 1'b0;
        end else if (!state_ff.done) begin
            // Strap window: inputs only, pulls give the default levels
            nxt_state.padOut = 11'h000;
            nxt_state.padOeN = 11'h7ff;
            nxt_state.padUp = slps_pkg::STRAP_PULL_UP;
            nxt_state.padDown = slps_pkg::STRAP_PULL_DOWN;
            nxt_state.hostPd = 1'b1;
            nxt_state.xtalOut = 1'b0;
            nxt_state.xtalOeN = 1'b1;
            nxt_state.xtalPd = 1'b1;
        end else begin
            nxt_state.padOut = state_ff.outVal;
            nxt_state.padOeN = ~state_ff.drive;
            // Both pulls asked for: the pull-up wins, never both at once
            nxt_state.padUp = state_ff.pullUpReg;
            nxt_state.padDown = state_ff.pullDownReg & ~state_ff.pullUpReg;
            nxt_state.hostPd = 1'b0;
            nxt_state.xtalOut = crystalRequest ^ state_ff.straps[slps_pkg::ST_XTAL_POL_BIT];
            nxt_state.xtalOeN = 1'b0;
            nxt_state.xtalPd = 1'b0;
        end
    end

    always_ff @(posedge clk) begin
        if (reset) begin
            state_ff.phase <= PH_WAIT_POWER;
            state_ff.delayCnt <= '0;
            state_ff.straps <= '0;
            state_ff.done <= 1'b0;
            state_ff.outVal <= slps_pkg::GPIO_OUT_RST;
            state_ff.drive <= slps_pkg::GPIO_DRIVE_RST;
            state_ff.pullUpReg <= slps_pkg::PULL_UP_RST;
            state_ff.pullDownReg <= slps_pkg::PULL_DOWN_RST;
            state_ff.ctrl <= slps_pkg::CTRL_RST;
            state_ff.ack <= 1'b0;
            state_ff.rdata <= 32'h0;
            state_ff.padOut <= 11'h000;
            state_ff.padOeN <= 11'h7ff;
            state_ff.padUp <= 11'h000;
            state_ff.padDown <= 11'h000;
            state_ff.padKeep <= 11'h000;
            state_ff.hostPd <= 1'b0;
            state_ff.xtalOut <= 1'b0;
            state_ff.xtalOeN <= 1'b1;
            state_ff.xtalPd <= 1'b0;
            state_ff.regPd <= 1'b1;
            state_ff.powered <= 1'b0;
        end else begin
            state_ff <= nxt_state;
        end
    end

    assign readdata = state_ff.rdata;
    assign gpioOut = state_ff.padOut;
    assign gpioOeN = state_ff.padOeN;
    assign gpioPullUp = state_ff.padUp;
    assign gpioPullDown = state_ff.padDown;
    assign gpioKeeper = state_ff.padKeep;
    assign hostStrapPullDown = state_ff.hostPd;
    assign crystal_powerup_out = state_ff.xtalOut;
    assign crystalPadOeN = state_ff.xtalOeN;
    assign crystalPadPullDown = state_ff.xtalPd;
    assign regEnablePullDown = state_ff.regPd;
    assign sectionReset = !state_ff.powered;
    assign regulatorsOn = state_ff.powered;

    assign strapDone = state_ff.done;
    assign hostMode = state_ff.straps[slps_pkg::ST_HOST_LSB+:2];
    assign fuseMemoryPowerOn = state_ff.straps[slps_pkg::ST_FUSE_BIT];
    assign flashPresent = state_ff.straps[slps_pkg::ST_FLASH_PRESENT_BIT];
    assign flashVendorFirst = state_ff.straps[slps_pkg::ST_FLASH_VENDOR_BIT];
    assign bootFromRom = state_ff.straps[slps_pkg::ST_BOOT_ROM_BIT];
    // Level 11 is passed on as strapped; its clock fitness is a board matter
    assign power_up_level_strap = state_ff.straps[slps_pkg::ST_LEVEL_LSB+:2];
    // Core stays in reset whatever the boot source, until software lets it run
    assign coreHoldReset = !state_ff.powered || !state_ff.ctrl[slps_pkg::CTRL_CORE_RUN_BIT];
endmodule
`default_nettype wire

// ### verification/slps_top_props.sv
`timescale 1ns/100ps
`default_nettype none
module slps_top_props #(
    parameter int unsigned STRAP_DELAY_CYCLES = 8
) (
    input wire logic clk, // Clock
    input wire logic reset, // Reset
    input wire logic regulator_enable_in, // Enable pin
    input wire logic [10:0] gpioOeN, // Pad enables
    input wire logic [10:0] gpioPullUp, // Pull-ups
    input wire logic [10:0] gpioPullDown, // Pull-downs
    input wire logic [10:0] gpioKeeper, // Keepers
    input wire logic hostStrapPullDown, // Host pull
    input wire logic crystalPadOeN, // Crystal enable
    input wire logic crystalPadPullDown, // Crystal pull
    input wire logic regEnablePullDown, // Enable pull
    input wire logic sectionReset, // Section reset
    input wire logic regulatorsOn, // Regulators
    input wire logic coreHoldReset, // Core held
    input wire logic strapDone, // Latched
    input wire logic [1:0] hostMode, // Host mode
    input wire logic [1:0] power_up_level_strap, // Level
    input wire logic bootFromRom // Boot source
);
    typedef struct packed {
        logic [19:0] hiCnt;
    } slps_chk_type;
    slps_chk_type st_ff, nxt_st;
    // Cycles the enable pin has stayed high, saturating
    always_comb begin
        nxt_st = st_ff;
        if (!regulator_enable_in) begin
            nxt_st.hiCnt = 20'h0;
        end else if (st_ff.hiCnt != 20'hfffff) begin
            nxt_st.hiCnt = st_ff.hiCnt + 20'h1;
        end
    end
    always_ff @(posedge clk) begin
        if (reset) begin
            st_ff <= 20'h0;
        end else begin
            st_ff <= nxt_st;
        end
    end
    default clocking @(posedge clk); endclocking
    default disable iff (reset);
    a_pads_off: assert property (
        !regulator_enable_in [*3] |=> gpioOeN == 11'h7ff && (gpioPullUp | gpioPullDown) == 11'h0)
        else $error("pads not released");
    a_keeper_gone: assert property (
        !regulator_enable_in [*3] |=> gpioKeeper == 11'h0)
        else $error("keepers on in power-down");
    a_keeper_on: assert property (
        regulator_enable_in [*4] |=> gpioKeeper == 11'h7ff)
        else $error("keepers off while powered");
    a_regpd_kept: assert property (
        !regulator_enable_in [*3] |=> regEnablePullDown)
        else $error("enable pull-down dropped");
    a_section_held: assert property (
        !regulator_enable_in [*3] |=> sectionReset && !regulatorsOn && coreHoldReset)
        else $error("section not held");
    a_regs_up: assert property (
        regulator_enable_in [*3] |=> !sectionReset && regulatorsOn)
        else $error("regulators not up");
    a_straps_hold: assert property (
        strapDone |=> strapDone && $stable({hostMode, power_up_level_strap, bootFromRom}))
        else $error("latched straps changed");
    a_done_delay: assert property (
        $rose(strapDone) |-> st_ff.hiCnt >= STRAP_DELAY_CYCLES
        && st_ff.hiCnt <= STRAP_DELAY_CYCLES + 4)
        else $error("strap sampling at wrong time");
    a_strap_pulls: assert property (
        regulator_enable_in [*3] ##1 !strapDone |-> gpioPullUp == 11'h2ae
        && gpioPullDown == 11'h541 && hostStrapPullDown && crystalPadPullDown)
        else $error("strap window pulls wrong");
    a_pads_handover: assert property (
        $rose(strapDone) |=> !hostStrapPullDown && !crystalPadPullDown && !crystalPadOeN)
        else $error("pads not handed over");
    cover property ($rose(strapDone));
    cover property ($fell(regulatorsOn));
    cover property (!regEnablePullDown && regulatorsOn);
endmodule
bind slps_top slps_top_props #(.STRAP_DELAY_CYCLES(STRAP_DELAY_CYCLES)) chk_u (
    .clk, .reset, .regulator_enable_in, .gpioOeN, .gpioPullUp, .gpioPullDown, .gpioKeeper,
    .hostStrapPullDown, .crystalPadOeN, .crystalPadPullDown, .regEnablePullDown, .sectionReset,
    .regulatorsOn, .coreHoldReset, .strapDone, .hostMode, .power_up_level_strap, .bootFromRom);
`default_nettype wire

// ### verification/slps_board.sv
`timescale 1ns/100ps
`default_nettype none
module slps_board (
    input wire logic clk, // Clock
    input wire logic regOn, // Supply sequencer enable
    input wire logic resEn, // External resistors fitted
    input wire logic [12:0] resVal, // Crystal, host, pads
    input wire logic [10:0] gpioOut, // Drive value
    input wire logic [10:0] gpioOeN, // Low while driving
    input wire logic [10:0] gpioPullUp, // Pull-ups
    input wire logic [10:0] gpioPullDown, // Pull-downs
    input wire logic hostStrapPullDown, // Host pull
    input wire logic crystal_powerup_out, // Crystal drive
    input wire logic crystalPadOeN, // Low while driving
    input wire logic crystalPadPullDown, // Crystal pull
    output logic [10:0] gpioIn, // Pad levels
    output logic hostStrapIn, // Host pad level
    output logic crystalPadIn, // Crystal pad level
    output logic regulator_enable_in // Enable pin
);
    logic [12:0] drv, oeN, pu, pd, lvl;
    logic flip_ff = 1'b0;
    always @(posedge clk) flip_ff <= ~flip_ff;
    assign drv = {crystal_powerup_out, 1'b0, gpioOut};
    assign oeN = {crystalPadOeN, 1'b1, gpioOeN};
    assign pu = {2'h0, gpioPullUp};
    assign pd = {crystalPadPullDown, hostStrapPullDown, gpioPullDown};
    always_comb begin
        for (int i = 0; i < 13; i++) begin
            if (!oeN[i]) lvl[i] = drv[i];
            else if (resEn) lvl[i] = resVal[i]; // Resistor beats pulls
            else if (pu[i]) lvl[i] = 1'b1;
            else if (pd[i]) lvl[i] = 1'b0;
            else lvl[i] = flip_ff ^ i[0]; // Floating pad: no stable level
        end
    end
    assign {crystalPadIn, hostStrapIn, gpioIn} = lvl;
    assign regulator_enable_in = regOn;
endmodule
`default_nettype wire

// ### verification/testbench.sv
`timescale 1ns/100ps
`default_nettype none
module testbench;
    localparam int DLY = 12;
    logic clk = 1'b0;
    logic reset = 1'b1;
    logic [4:0] address = 5'h0;
    logic read = 1'b0;
    logic write = 1'b0;
    logic [3:0] byteenable = 4'hf;
    logic [31:0] writedata = 32'h0;
    logic crystalRequest = 1'b0;
    logic regOn = 1'b0;
    logic resEn = 1'b0;
    logic [12:0] resVal = 13'h0;
    logic [31:0] readdata, rd;
    logic [10:0] gpioIn, gpioOut, gpioOeN, gpioPullUp, gpioPullDown, gpioKeeper;
    logic waitrequest, hostStrapIn, hostStrapPullDown, crystalPadIn, crystal_powerup_out;
    logic crystalPadOeN, crystalPadPullDown, regulator_enable_in, regEnablePullDown;
    logic sectionReset, regulatorsOn, strapDone, fuseMemoryPowerOn, flashPresent;
    logic flashVendorFirst, bootFromRom, coreHoldReset;
    logic [1:0] hostMode, power_up_level_strap;
    int errCount = 0;
    int numChecks = 0;
    always #10 clk = ~clk;
    slps_top #(.STRAP_DELAY_CYCLES(DLY)) dut_u (.clk, .reset, .address, .read, .write,
        .byteenable, .writedata, .readdata, .waitrequest, .gpioIn, .gpioOut, .gpioOeN,
        .gpioPullUp, .gpioPullDown, .gpioKeeper, .hostStrapIn, .hostStrapPullDown,
        .crystalPadIn, .crystalRequest, .crystal_powerup_out, .crystalPadOeN,
        .crystalPadPullDown, .regulator_enable_in, .regEnablePullDown, .sectionReset,
        .regulatorsOn, .strapDone, .hostMode, .fuseMemoryPowerOn, .flashPresent,
        .flashVendorFirst, .bootFromRom, .power_up_level_strap, .coreHoldReset);
    slps_board board_u (.clk, .regOn, .resEn, .resVal, .gpioOut, .gpioOeN, .gpioPullUp,
        .gpioPullDown, .hostStrapPullDown, .crystal_powerup_out, .crystalPadOeN,
        .crystalPadPullDown, .gpioIn, .hostStrapIn, .crystalPadIn, .regulator_enable_in);
    task check(input string name, input logic [63:0] seen, input logic [63:0] exp);
        numChecks++;
        if (seen !== exp) begin
            errCount++;
            $display("FAIL %s expected %h seen %h", name, exp, seen);
        end
    endtask
    task wrapUp;
        $display("Checks %0d, mismatches %0d", numChecks, errCount);
        if (errCount == 0 && numChecks > 0) begin
            $display("No errors found");
        end else begin
            $display("Errors were found");
        end
        $finish;
    endtask
    task waitn(input int n);
        repeat (n) @(posedge clk);
        @(negedge clk);
    endtask
    task bus(input logic wr, input logic [4:0] a, input logic [31:0] d, input logic [3:0] be);
        int n;
        n = 0;
        @(posedge clk);
        address <= a;
        writedata <= d;
        byteenable <= be;
        write <= wr;
        read <= ~wr;
        do begin
            @(negedge clk);
            n++;
        end while (waitrequest !== 1'b0 && n < 20);
        check("waitrequest", waitrequest, 1'b0);
        @(posedge clk);
        rd = readdata;
        write <= 1'b0;
        read <= 1'b0;
    endtask
    task power_on(input logic en, input logic [12:0] val);
        @(posedge clk);
        reset <= 1'b1;
        regOn <= 1'b0;
        resEn <= en;
        resVal <= val;
        repeat (8) @(posedge clk);
        reset <= 1'b0;
        repeat (2) @(posedge clk);
        regOn <= 1'b1;
        waitn(4);
        check("window pulls", {gpioPullUp, gpioPullDown, hostStrapPullDown, crystalPadPullDown},
            {slps_pkg::STRAP_PULL_UP, slps_pkg::STRAP_PULL_DOWN, 2'h3});
        for (int i = 0; i < 4 * DLY && strapDone !== 1'b1; i++) @(negedge clk);
        check("strapDone", strapDone, 1'b1);
        waitn(3);
    endtask
    task s_straps(input logic en, input logic [12:0] val, input logic [31:0] exp);
        power_on(en, val);
        bus(1'b0, slps_pkg::REG_STRAP, 32'h0, 4'hf);
        check("strap reg", rd, exp);
        check("modes", {hostMode, power_up_level_strap}, {exp[1:0], exp[7:6]});
        check("flags", {bootFromRom, flashVendorFirst, flashPresent, fuseMemoryPowerOn},
            exp[5:2]);
        check("core held", coreHoldReset, 1'b1);
        check("pulls", {gpioPullUp, gpioPullDown, hostStrapPullDown, crystalPadPullDown},
            {slps_pkg::PULL_UP_RST, slps_pkg::PULL_DOWN_RST, 2'h0});
        check("keeper", gpioKeeper, 11'h7ff);
        crystalRequest <= 1'b1;
        waitn(3);
        check("crystal on", {crystalPadOeN, crystal_powerup_out}, {1'b0, ~exp[8]});
        @(posedge clk);
        crystalRequest <= 1'b0;
        resEn <= 1'b1;
        resVal <= ~val;
        waitn(3);
        check("crystal off", crystal_powerup_out, exp[8]);
        bus(1'b0, slps_pkg::REG_STRAP, 32'h0, 4'hf);
        check("strap held", rd, exp);
    endtask
    task s_program;
        bus(1'b1, slps_pkg::REG_PULL_UP, 32'h10, 4'h3);
        bus(1'b1, slps_pkg::REG_PULL_DOWN, 32'h401, 4'h3);
        bus(1'b1, slps_pkg::REG_CTRL, 32'h3, 4'h1);
        bus(1'b1, slps_pkg::REG_GPIO_DRIVE, 32'h4, 4'h3);
        bus(1'b1, slps_pkg::REG_GPIO_OUT, 32'h4, 4'h3);
        bus(1'b1, slps_pkg::REG_STRAP, 32'h0, 4'hf);
        bus(1'b0, 5'h1c, 32'h0, 4'hf);
        check("unmapped", rd, 32'h0);
        bus(1'b0, slps_pkg::REG_PULL_UP, 32'h0, 4'hf);
        check("pull readback", rd, 32'h10);
        bus(1'b0, slps_pkg::REG_GPIO_IN, 32'h0, 4'hf);
        check("pad levels", rd, 32'h7ff);
        waitn(2);
        check("prog pulls", {gpioPullUp, gpioPullDown}, {11'h010, 11'h401});
        check("enable pd off", regEnablePullDown, 1'b0);
        check("pad drive", {gpioOeN[2], gpioOut[2]}, 2'h1);
        check("core run", coreHoldReset, 1'b0);
    endtask
    task s_power(input logic [31:0] exp);
        @(posedge clk);
        regOn <= 1'b0;
        waitn(4);
        check("off oe", gpioOeN, 11'h7ff);
        check("off pulls", {gpioPullUp, gpioPullDown, gpioKeeper}, 33'h0);
        check("off state", {sectionReset, regulatorsOn, coreHoldReset, regEnablePullDown},
            4'hb);
        @(posedge clk);
        regOn <= 1'b1;
        waitn(4);
        check("on state", {sectionReset, regulatorsOn, regEnablePullDown}, 3'h3);
        check("on pulls", {gpioPullUp, gpioPullDown},
            {slps_pkg::PULL_UP_RST, slps_pkg::PULL_DOWN_RST});
        bus(1'b0, slps_pkg::REG_STRAP, 32'h0, 4'hf);
        check("strap kept", rd, exp);
    endtask
    initial begin
        repeat (5000) @(posedge clk);
        errCount++;
        $display("FAIL watchdog expected finish seen timeout");
        wrapUp();
    end
    initial begin
        // Board never straps the power-up level to 11
        s_straps(1'b0, 13'h0000, 32'h800000a4);
        s_program();
        s_power(32'h800000a4);
        s_straps(1'b1, 13'h1d01, 32'h80000159);
        s_straps(1'b1, 13'h0280, 32'h80000024);
        wrapUp();
    end
endmodule
`default_nettype wire
